/* scsc_top.sv */
// System clock source control: register, clock switch, ready flag, detectors
//
// Behaviour
// RULE1: Any reset returns the system clock to the internal oscillator.
// RULE2: Internal oscillator clock is usable at once when enabled, no wait.
// RULE3: Both oscillators stay disabled while the reset pin is low.
// RULE4: Bit 3 selects system clock: 0 internal, 1 external, changeable anytime.
// RULE5: External oscillator may keep running while internal clock is selected.
// RULE6: Bit 2 turns the internal oscillator off (0) or on (1).
// RULE7: Two-bit field picks 2, 4, 8 or 16 MHz internal frequency.
// RULE8: Ready flag reads 1 only when internal oscillator runs at chosen frequency.
// RULE9: Bit 7 enables the missing-clock detector, which forces reset.
// RULE10: Missing-clock reset follows about 220 us after the last clock edge.
// RULE11: After power crosses threshold, reset pin is held low about 100 ms.
// RULE12: Bits 6 and 5 read zero and ignore writes.
// RULE13: Source switching produces no runt pulses or glitches.
`timescale 1ns/1ps
`include "scsc_consts.svh"
module scsc_top #(
  parameter int unsigned MCD_CYCLES = `SCSC_MCD_CYCLES,
  parameter int unsigned POR_CYCLES = `SCSC_POR_CYCLES
) (
  input  wire logic        clock_i,            // Free-running reference clock
  input  wire logic        rst_i,              // Async reset, high
  input  wire logic [9:0]  avs_address_i,      // Byte address
  input  wire logic        avs_read_i,         // Read request
  input  wire logic        avs_write_i,        // Write request
  input  wire logic [31:0] avs_writedata_i,    // Write data
  output logic      [31:0] avs_readdata_o,     // Read data
  output logic             avs_waitrequest_o,  // Stall
  input  wire logic        rst_pin_n_i,        // Reset pin level
  input  wire logic        por_ok_i,           // Supply above threshold
  input  wire logic        int_osc_lock_i,     // Internal osc settled
  input  wire logic        sys_clk_beat_i,     // Toggles each system clock
  output logic             rst_pin_o,          // Reset pin drive value
  output logic             rst_pin_oe_o,       // Reset pin drive enable
  output logic             int_osc_en_o,       // Internal osc enable
  output logic      [1:0]  int_freq_sel_o,     // Internal osc frequency code
  output logic             ext_osc_allow_o,    // External osc permitted
  output logic             int_clk_gate_o,     // Internal clock onto mux
  output logic             ext_clk_gate_o,     // External clock onto mux
  output logic             mcd_reset_o,        // Missing-clock reset
  output logic             irq_o               // Interrupt, level
);
  import scsc_pkg::*;

  // Two-flop synchronisers for all pin inputs
  logic [3:0] async_in;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic       beat_d_r;
  assign async_in = {rst_pin_n_i, por_ok_i, int_osc_lock_i, sys_clk_beat_i};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= async_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  logic pin_low;
  logic por_s;
  logic lock_s;
  logic beat_edge;
  assign pin_low   = !sync2_r[3];
  assign por_s     = sync2_r[2];
  assign lock_s    = sync2_r[1];
  assign beat_edge = sync2_r[0] ^ beat_d_r;

  // State
  scsc_ctrl_t  ctrl_r,  ctrl_nxt;
  scsc_evt_t   stat_r,  stat_nxt;
  scsc_evt_t   mask_r,  mask_nxt;
  scsc_evt_t   evt;
  scsc_sw_t    sw_r,    sw_nxt;
  logic        tgt_ext_r, tgt_ext_nxt;
  logic [2:0]  brk_r,   brk_nxt;
  logic [4:0]  settle_r, settle_nxt;
  logic        rdy_r,   rdy_nxt;
  logic [2:0]  pulse_r, pulse_nxt;
  logic        wait_r,  wait_nxt;
  logic [31:0] rdata_nxt;
  logic        irq_nxt;
  logic        ien_eff;
  logic        mcd_expired;
  logic        por_done;
  logic        dev_rst;
  logic        wr_go;
  logic        rd_take;

  assign dev_rst = pin_low || mcd_reset_o;
  assign wr_go   = avs_write_i && !wait_r;
  assign rd_take = avs_read_i && wait_r;
  assign ien_eff = ctrl_r.ien && !pin_low;                              // RULE3 RULE6

  // Bus slave: one wait cycle, then the answer
  always_comb begin
    wait_nxt  = !((avs_read_i || avs_write_i) && wait_r);
    rdata_nxt = avs_readdata_o;
    if (rd_take) begin
      unique case (avs_address_i)
        `SCSC_CTRL_ADDR: rdata_nxt = {24'h00_0000, ctrl_r.mce, 2'b00, rdy_r,
                                      ctrl_r.csel, ctrl_r.ien, ctrl_r.fsel}; // RULE12 RULE8
        `SCSC_STAT_ADDR: rdata_nxt = {29'h0000_0000, stat_r};
        `SCSC_MASK_ADDR: rdata_nxt = {29'h0000_0000, mask_r};
        default:         rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Control register; any device reset restores defaults
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (dev_rst) begin
      ctrl_nxt = scsc_ctrl_t'(`SCSC_CTRL_RESET);                        // RULE1
    end else if (wr_go && avs_address_i == `SCSC_CTRL_ADDR) begin
      ctrl_nxt.mce  = avs_writedata_i[`SCSC_MCE_BIT];                   // RULE9
      ctrl_nxt.csel = avs_writedata_i[`SCSC_CSEL_BIT];                  // RULE4
      ctrl_nxt.ien  = avs_writedata_i[`SCSC_IEN_BIT];                   // RULE6
      ctrl_nxt.fsel = avs_writedata_i[`SCSC_FSEL_LSB +: 2];             // RULE7
    end
    ctrl_nxt.unused = 2'b00;                                            // RULE12
    ctrl_nxt.rdy    = 1'b0;
  end

  // Break-before-make clock switch
  always_comb begin
    sw_nxt      = sw_r;
    tgt_ext_nxt = tgt_ext_r;
    brk_nxt     = brk_r;
    evt.sw_done = 1'b0;
    if (dev_rst) begin
      sw_nxt      = SW_INT;                                             // RULE1
      tgt_ext_nxt = 1'b0;
      brk_nxt     = 3'h0;
    end else begin
      unique case (sw_r)
        SW_INT: if (ctrl_r.csel) begin                                  // RULE4
          sw_nxt      = SW_BRK;
          tgt_ext_nxt = 1'b1;
          brk_nxt     = 3'h0;
        end
        SW_EXT: if (!ctrl_r.csel) begin
          sw_nxt      = SW_BRK;
          tgt_ext_nxt = 1'b0;
          brk_nxt     = 3'h0;
        end
        SW_BRK: begin
          if (brk_r == `SCSC_BREAK_CYCLES - 3'h1) begin                 // RULE13
            sw_nxt      = tgt_ext_r ? SW_EXT : SW_INT;
            evt.sw_done = 1'b1;
          end else begin
            brk_nxt = brk_r + 3'h1;
          end
        end
        default: sw_nxt = SW_INT;
      endcase
    end
  end

  // Ready flag: enabled, locked, frequency unchanged for the settle time
  always_comb begin
    settle_nxt = settle_r;
    if (!ien_eff || !lock_s || ctrl_r.fsel != int_freq_sel_o) begin
      settle_nxt = 5'h00;                                               // RULE8
    end else if (settle_r != `SCSC_RDY_SETTLE) begin
      settle_nxt = settle_r + 5'h01;
    end
    rdy_nxt      = (settle_nxt == `SCSC_RDY_SETTLE) && !dev_rst;
    evt.rdy_rise = rdy_nxt && !rdy_r;
  end

  // Missing-clock detector; a held pulse resets the block and the device
  scsc_timer #(.LIMIT(MCD_CYCLES)) u_mcd_timer (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .restart_i (beat_edge || !ctrl_r.mce),                              // RULE9
    .run_i     (ctrl_r.mce && !dev_rst),
    .expired_o (mcd_expired)                                            // RULE10
  );

  always_comb begin
    pulse_nxt = pulse_r;
    evt.mcd   = 1'b0;
    if (pulse_r != 3'h0) begin
      pulse_nxt = pulse_r - 3'h1;
    end else if (mcd_expired && ctrl_r.mce) begin
      pulse_nxt = `SCSC_MCD_PULSE;                                      // RULE9
      evt.mcd   = 1'b1;
    end
  end

  // Power-on delay holds the reset pin low
  scsc_timer #(.LIMIT(POR_CYCLES)) u_por_timer (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .restart_i (!por_s),
    .run_i     (por_s),
    .expired_o (por_done)                                               // RULE11
  );

  // Sticky status: set wins over write-one-to-clear
  always_comb begin
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    if (wr_go && avs_address_i == `SCSC_STAT_ADDR) begin
      stat_nxt = stat_r & ~scsc_evt_t'(avs_writedata_i[2:0]);
    end
    if (wr_go && avs_address_i == `SCSC_MASK_ADDR) begin
      mask_nxt = scsc_evt_t'(avs_writedata_i[2:0]);
    end
    stat_nxt = stat_nxt | evt;
    irq_nxt  = |(stat_r & mask_r);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r            <= scsc_ctrl_t'(`SCSC_CTRL_RESET);
      stat_r            <= scsc_evt_t'(`SCSC_EVT_RESET);
      mask_r            <= scsc_evt_t'(`SCSC_EVT_RESET);
      sw_r              <= SW_INT;
      tgt_ext_r         <= 1'b0;
      brk_r             <= 3'h0;
      settle_r          <= 5'h00;
      rdy_r             <= 1'b0;
      pulse_r           <= 3'h0;
      wait_r            <= 1'b1;
      beat_d_r          <= 1'b0;
      avs_readdata_o    <= 32'h0000_0000;
      avs_waitrequest_o <= 1'b1;
      rst_pin_o         <= 1'b0;
      rst_pin_oe_o      <= 1'b1;
      int_osc_en_o      <= 1'b0;
      int_freq_sel_o    <= 2'b00;
      ext_osc_allow_o   <= 1'b0;
      int_clk_gate_o    <= 1'b0;
      ext_clk_gate_o    <= 1'b0;
      mcd_reset_o       <= 1'b0;
      irq_o             <= 1'b0;
    end else begin
      ctrl_r            <= ctrl_nxt;
      stat_r            <= stat_nxt;
      mask_r            <= mask_nxt;
      sw_r              <= sw_nxt;
      tgt_ext_r         <= tgt_ext_nxt;
      brk_r             <= brk_nxt;
      settle_r          <= settle_nxt;
      rdy_r             <= rdy_nxt;
      pulse_r           <= pulse_nxt;
      wait_r            <= wait_nxt;
      beat_d_r          <= sync2_r[0];
      avs_readdata_o    <= rdata_nxt;
      avs_waitrequest_o <= wait_nxt;
      rst_pin_o         <= 1'b0;
      rst_pin_oe_o      <= !por_done;                                   // RULE11
      int_osc_en_o      <= ien_eff;                                     // RULE2
      int_freq_sel_o    <= ctrl_r.fsel;                                 // RULE7
      ext_osc_allow_o   <= !pin_low;                                    // RULE3 RULE5
      int_clk_gate_o    <= (sw_nxt == SW_INT) && !pin_low;              // RULE13
      ext_clk_gate_o    <= (sw_nxt == SW_EXT) && !pin_low;              // RULE13
      mcd_reset_o       <= (pulse_nxt != 3'h0);
      irq_o             <= irq_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  property p_rst_int;
    dev_rst |=> !ext_clk_gate_o && sw_r == SW_INT;
  endproperty
  a_rst_int: assert property (p_rst_int) else $error("reset left external clock"); // RULE1

  property p_int_now;
    !pin_low && ctrl_r.ien && !ctrl_r.csel && sw_r == SW_INT && !dev_rst ##1 !pin_low
      |-> int_osc_en_o && int_clk_gate_o;
  endproperty
  a_int_now: assert property (p_int_now) else $error("internal clock delayed"); // RULE2

  property p_pin_off;
    pin_low |=> !int_osc_en_o && !ext_osc_allow_o;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("oscillator on while pin low"); // RULE3

  sequence s_want_ext;
    sw_r == SW_INT && ctrl_r.csel && !dev_rst;
  endsequence
  sequence s_stay_up;
    (!dev_rst && ctrl_r.csel)[*6];
  endsequence
  property p_to_ext;
    s_want_ext ##0 s_stay_up |-> ext_clk_gate_o;
  endproperty
  a_to_ext: assert property (p_to_ext) else $error("external clock not selected"); // RULE4

  property p_ext_run;
    !pin_low && ctrl_r.csel == 1'b0 |=> ext_osc_allow_o;
  endproperty
  a_ext_run: assert property (p_ext_run) else $error("external osc stopped"); // RULE5

  property p_ien;
    $fell(ctrl_r.ien) |=> !int_osc_en_o ##1 !rdy_r;
  endproperty
  a_ien: assert property (p_ien) else $error("internal osc not disabled"); // RULE6

  property p_fsel;
    $changed(ctrl_r.fsel) |=> int_freq_sel_o == $past(ctrl_r.fsel);
  endproperty
  a_fsel: assert property (p_fsel) else $error("frequency code not applied"); // RULE7

  property p_rdy;
    rdy_r |-> int_osc_en_o && $past(ctrl_r.fsel) == $past(int_freq_sel_o)
      && settle_r == `SCSC_RDY_SETTLE;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready flag without settled osc"); // RULE8

  property p_mcd_fire;
    mcd_expired && ctrl_r.mce && pulse_r == 3'h0 |=> mcd_reset_o [*4] ##1 !mcd_reset_o;
  endproperty
  a_mcd_fire: assert property (p_mcd_fire) else $error("missing-clock reset wrong"); // RULE9

  property p_por;
    !por_done |=> rst_pin_oe_o && !rst_pin_o;
  endproperty
  a_por: assert property (p_por) else $error("reset pin released early"); // RULE11

  property p_unused;
    avs_read_i && !wait_r && avs_address_i == `SCSC_CTRL_ADDR |-> avs_readdata_o[6:5] == 2'b00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bits not zero"); // RULE12

  property p_break;
    $rose(ext_clk_gate_o) || ($rose(int_clk_gate_o) && $past(sw_r) == SW_BRK)
      |-> $past(!int_clk_gate_o && !ext_clk_gate_o, 2);
  endproperty
  a_break: assert property (p_break) else $error("no gap between sources"); // RULE13

  property p_excl;
    !(int_clk_gate_o && ext_clk_gate_o);
  endproperty
  a_excl: assert property (p_excl) else $error("both sources gated on"); // RULE13

endmodule : scsc_top

/* scsc_consts.svh */
// Offsets, field positions, reset values and timing counts of the clock source control
`ifndef SCSC_CONSTS_SVH
`define SCSC_CONSTS_SVH

// Register indices; byte address is four times the index
`define SCSC_CTRL_IDX      8'hB2
`define SCSC_STAT_IDX      8'hB3
`define SCSC_MASK_IDX      8'hB4
`define SCSC_CTRL_ADDR     {`SCSC_CTRL_IDX, 2'b00}
`define SCSC_STAT_ADDR     {`SCSC_STAT_IDX, 2'b00}
`define SCSC_MASK_ADDR     {`SCSC_MASK_IDX, 2'b00}

// Control register field positions and reset value
`define SCSC_MCE_BIT       7
`define SCSC_RDY_BIT       4
`define SCSC_CSEL_BIT      3
`define SCSC_IEN_BIT       2
`define SCSC_FSEL_LSB      0
`define SCSC_CTRL_RESET    8'h04

// Status and mask field positions
`define SCSC_EVT_MCD_BIT   0
`define SCSC_EVT_RDY_BIT   1
`define SCSC_EVT_SW_BIT    2
`define SCSC_EVT_RESET     3'h0

// Timing
`define SCSC_CLK_PERIOD_NS 10
`define SCSC_MCD_TIME_NS   220000
`define SCSC_MCD_CYCLES    (`SCSC_MCD_TIME_NS / `SCSC_CLK_PERIOD_NS)
`define SCSC_POR_TIME_NS   100000000
`define SCSC_POR_CYCLES    (`SCSC_POR_TIME_NS / `SCSC_CLK_PERIOD_NS)
`define SCSC_BREAK_CYCLES  3'h4
`define SCSC_MCD_PULSE     3'h4
`define SCSC_RDY_SETTLE    5'h10

`endif

/* scsc_pkg.sv */
// Types shared by the clock source control
package scsc_pkg;

  typedef struct packed {
    logic       mce;
    logic [1:0] unused;
    logic       rdy;
    logic       csel;
    logic       ien;
    logic [1:0] fsel;
  } scsc_ctrl_t;

  typedef struct packed {
    logic sw_done;
    logic rdy_rise;
    logic mcd;
  } scsc_evt_t;

  typedef enum logic [2:0] {
    SW_INT = 3'b001,
    SW_BRK = 3'b010,
    SW_EXT = 3'b100
  } scsc_sw_t;

endpackage : scsc_pkg

/* scsc_timer.sv */
// Restartable timeout counter
`timescale 1ns/1ps
module scsc_timer #(
  parameter int unsigned LIMIT = 16
) (
  input  wire logic clock_i,    // Clock
  input  wire logic rst_i,      // Async reset, high
  input  wire logic restart_i,  // Clear count
  input  wire logic run_i,      // Count enable
  output logic      expired_o   // Count reached limit
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        exp_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (restart_i || !run_i) begin
      cnt_nxt = 32'h0000_0000;
    end else if (cnt_r != LIMIT) begin
      cnt_nxt = cnt_r + 32'h0000_0001;
    end
    exp_nxt = (cnt_nxt == LIMIT);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r     <= 32'h0000_0000;
      expired_o <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      expired_o <= exp_nxt;
    end
  end

  property p_limit;
    @(posedge clock_i) disable iff (rst_i)
    $rose(expired_o) |-> (cnt_r == LIMIT) && $past(run_i) && !$past(restart_i);
  endproperty
  a_limit: assert property (p_limit) else $error("timer expired early"); // RULE10

endmodule : scsc_timer

/* scsc_top_tb.sv */
// Self-checking bench for the system clock source control
`timescale 1ns/1ps
`include "scsc_consts.svh"
module scsc_top_tb;
  import scsc_pkg::*;
  localparam int unsigned MCD = 50;
  localparam int unsigned POR = 100;
  logic        clock_i;
  logic        rst_i;
  logic [9:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  wire logic   rst_pin_n_i;
  logic        ext_rst_n;
  logic        por_ok_i;
  logic        int_osc_lock_i;
  logic        sys_clk_beat_i;
  logic        beat_en;
  logic        rst_pin_o;
  logic        rst_pin_oe_o;
  logic        int_osc_en_o;
  logic [1:0]  int_freq_sel_o;
  logic        ext_osc_allow_o;
  logic        int_clk_gate_o;
  logic        ext_clk_gate_o;
  logic        mcd_reset_o;
  logic        irq_o;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] seed;
  int          fails;
  int          check_count;
  int          n;

  // Open-drain reset pin with pull-up: low if either party pulls it
  assign rst_pin_n_i = ext_rst_n & ~(rst_pin_oe_o & ~rst_pin_o);

  scsc_top #(.MCD_CYCLES(MCD), .POR_CYCLES(POR)) DUT (
    .clock_i(clock_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .rst_pin_n_i(rst_pin_n_i), .por_ok_i(por_ok_i), .int_osc_lock_i(int_osc_lock_i),
    .sys_clk_beat_i(sys_clk_beat_i), .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o),
    .int_osc_en_o(int_osc_en_o), .int_freq_sel_o(int_freq_sel_o),
    .ext_osc_allow_o(ext_osc_allow_o), .int_clk_gate_o(int_clk_gate_o),
    .ext_clk_gate_o(ext_clk_gate_o), .mcd_reset_o(mcd_reset_o), .irq_o(irq_o));

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
  endtask : cyc

  // Request held until waitrequest is sampled low
  task automatic bus_cycle(input logic [9:0] a, input logic wr, input logic [31:0] d);
    int k;
    @(posedge clock_i);
    avs_address_i   <= a;
    avs_read_i      <= ~wr;
    avs_write_i     <= wr;
    avs_writedata_i <= d;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 20);
    if (k >= 20) begin
      fails++;
      $display("[FAIL] %0t bus answer missing", $time);
    end
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus_cycle

  task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
    bus_cycle(a, 1'b1, d);
  endtask : wr_reg

  task automatic rd_reg(input logic [9:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus_cycle(a, 1'b0, 32'h0000_0000);
  endtask : rd_reg

  // Read results compared against the oldest note; gates watched each cycle
  always @(posedge clock_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("[FAIL] %0t read with no expectation", $time);
      end else begin
        check(avs_readdata_o & msk_q.pop_front(), exp_q.pop_front(), "read data");
      end
    end
    if (int_clk_gate_o === 1'b1 && ext_clk_gate_o === 1'b1) begin
      fails++;
      $display("[FAIL] %0t both clock gates on", $time);
    end
  end

  always @(posedge clock_i) if (beat_en) sys_clk_beat_i <= ~sys_clk_beat_i;

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    #300000;
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    rst_i = 1'b1;
    avs_address_i = 10'h000;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0000_0000;
    ext_rst_n = 1'b1;
    por_ok_i = 1'b0;
    int_osc_lock_i = 1'b0;
    sys_clk_beat_i = 1'b0;
    beat_en = 1'b1;
    fails = 0;
    check_count = 0;
    seed = 32'h5c53;
    cyc(8);
    check(rst_pin_oe_o, 1'b1, "pin driven in reset");
    check(int_osc_en_o, 1'b0, "osc off in reset");
    rst_i <= 1'b0;
    // Power-on delay
    cyc(2);
    por_ok_i <= 1'b1;
    n = 0;
    while (rst_pin_oe_o !== 1'b0 && n < POR + 40) begin
      @(posedge clock_i);
      n++;
    end
    check(n >= POR && n <= POR + 8, 1'b1, "power-on delay");
    check(rst_pin_o, 1'b0, "pin drive level");
    cyc(8);
    check(int_osc_en_o, 1'b1, "internal osc at once");
    check(ext_osc_allow_o, 1'b1, "external allowed");
    check(int_clk_gate_o, 1'b1, "boot from internal");
    $display("test power_on done");
    ext_rst_n <= 1'b0;
    cyc(6);
    check({int_osc_en_o, ext_osc_allow_o}, 2'b00, "osc off pin low");
    ext_rst_n <= 1'b1;
    cyc(8);
    rd_reg(`SCSC_CTRL_ADDR, 32'h0000_0004, 32'hFFFF_FFFF);
    rd_reg(`SCSC_STAT_ADDR, 32'h0000_0000, 32'hFFFF_FFFF);
    rd_reg(`SCSC_MASK_ADDR, 32'h0000_0000, 32'hFFFF_FFFF);
    rd_reg(10'h3F0, 32'h0000_0000, 32'hFFFF_FFFF);
    wr_reg(10'h3F0, 32'hFFFF_FFFF);
    rd_reg(`SCSC_CTRL_ADDR, 32'h0000_0004, 32'hFFFF_FFFF);
    $display("test reset_values done");
    // Enable off, then every frequency code with ready tracking
    wr_reg(`SCSC_CTRL_ADDR, 32'h0000_0000);
    cyc(4);
    check(int_osc_en_o, 1'b0, "osc disabled");
    int_osc_lock_i <= 1'b1;
    for (int i = 1; i <= 4; i++) begin
      wr_reg(`SCSC_CTRL_ADDR, 32'h0000_0004 | (i % 4));
      rd_reg(`SCSC_CTRL_ADDR, 32'h0000_0004 | (i % 4), 32'h0000_00FF);
      cyc(30);
      check(int_freq_sel_o, i % 4, "freq code");
      check(int_osc_en_o, 1'b1, "osc enabled");
      rd_reg(`SCSC_CTRL_ADDR, 32'h0000_0014 | (i % 4), 32'h0000_00FF);
    end
    $display("test frequency done");
    // Source switch both ways
    rd_reg(`SCSC_STAT_ADDR, 32'h0000_0002, 32'hFFFF_FFFF);
    wr_reg(`SCSC_STAT_ADDR, 32'h0000_0007);
    wr_reg(`SCSC_CTRL_ADDR, 32'h0000_000C);
    n = 0;
    while (ext_clk_gate_o !== 1'b1 && n < 30) begin
      @(posedge clock_i);
      n++;
    end
    check(n >= 4 && n <= 12, 1'b1, "switch to external");
    check(int_clk_gate_o, 1'b0, "internal gate off");
    rd_reg(`SCSC_STAT_ADDR, 32'h0000_0004, 32'hFFFF_FFFF);
    wr_reg(`SCSC_CTRL_ADDR, 32'h0000_0004);
    cyc(12);
    check({int_clk_gate_o, ext_clk_gate_o}, 2'b10, "back to internal");
    check(ext_osc_allow_o, 1'b1, "external kept");
    $display("test switch done");
    // Interrupt raise, mask, clear
    check(irq_o, 1'b0, "irq masked");
    wr_reg(`SCSC_MASK_ADDR, 32'h0000_0004);
    cyc(3);
    check(irq_o, 1'b1, "irq raised");
    wr_reg(`SCSC_MASK_ADDR, 32'h0000_0000);
    cyc(3);
    check(irq_o, 1'b0, "irq masked off");
    wr_reg(`SCSC_MASK_ADDR, 32'h0000_0007);
    wr_reg(`SCSC_STAT_ADDR, 32'h0000_0007);
    cyc(3);
    check(irq_o, 1'b0, "irq cleared");
    $display("test interrupt done");
    // Missing clock: disabled detector stays quiet, enabled one fires
    beat_en <= 1'b0;
    n = 0;
    repeat (2 * MCD) begin
      @(posedge clock_i);
      if (mcd_reset_o !== 1'b0) n++;
    end
    check(n, 0, "detector idle");
    beat_en <= 1'b1;
    wr_reg(`SCSC_CTRL_ADDR, 32'h0000_008C);
    cyc(2 * MCD);
    check(mcd_reset_o, 1'b0, "clock present");
    beat_en <= 1'b0;
    n = 0;
    while (mcd_reset_o !== 1'b1 && n < 2 * MCD) begin
      @(posedge clock_i);
      n++;
    end
    check(n >= MCD - 4 && n <= MCD + 8, 1'b1, "detector timeout");
    beat_en <= 1'b1;
    cyc(12);
    check({int_clk_gate_o, ext_clk_gate_o}, 2'b10, "internal after reset");
    check(irq_o, 1'b1, "mcd event irq");
    rd_reg(`SCSC_CTRL_ADDR, 32'h0000_0004, 32'h0000_00EF);
    rd_reg(`SCSC_STAT_ADDR, 32'h0000_0001, 32'h0000_0001);
    $display("test missing_clock done");
    // Random control writes, unused bits must stay zero
    int_osc_lock_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      seed = lfsr_next(seed);
      wr_reg(`SCSC_CTRL_ADDR, seed);
      rd_reg(`SCSC_CTRL_ADDR, seed & 32'h0000_008F, 32'hFFFF_FFFF);
    end
    $display("test random_ctrl done");
    cyc(4);
    conclude();
  end
endmodule : scsc_top_tb
